// [pkg/flash_ctl_pkg.sv]
// Purpose: Shared constants and types of the suspend, resume and reset
//          control of the serial flash.
// Assumes: Core clock of 200 MHz.
// Notes:   Opcodes are the single byte seen after chip select falls.
package flash_ctl_pkg;

    localparam logic [7:0] OP_LATCH_CLR = 8'h04;
    localparam logic [7:0] OP_STATUS_RD = 8'h05;
    localparam logic [7:0] OP_CONFIG_RD = 8'h15;
    localparam logic [7:0] OP_SECURITY_RD = 8'h2b;
    localparam logic [7:0] OP_SIGNATURE_RD = 8'hab;
    localparam logic [7:0] OP_RESET_ARM = 8'h66;
    localparam logic [7:0] OP_RESET_FIRE = 8'h99;
    localparam logic [7:0] OP_IDLE = 8'h00;
    localparam logic [7:0] OP_RESUME_A = 8'h7a;
    localparam logic [7:0] OP_RESUME_B = 8'h30;
    localparam logic [7:0] OP_PARAM_RD = 8'h5a;

    localparam int IO_W = 4;
    localparam int SPI_CMD_CLKS = 8;
    localparam int QUAD_CMD_CLKS = 2;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_BYTES = 1;
    localparam int PARAM_HDR_BYTES = 1 + ADDR_BYTES + DUMMY_BYTES;

    localparam int WIP_BIT = 0;
    localparam int WEL_BIT = 1;
    localparam int PSB_BIT = 2;
    localparam int ESB_BIT = 3;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_PULSE_MIN_US = 10;
    localparam int RESET_PULSE_CYC =
        (RESET_PULSE_MIN_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        ST_STANDBY,
        ST_BUSY,
        ST_SUSPENDING,
        ST_SUSPENDED
    } mode_t;

endpackage

// [design/input_sync.sv]
// Purpose: Two-flop synchroniser for pins from outside the core clock.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
module input_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input logic ref_clk_in,
    input logic rst_in,
    input logic clk_en_in,
    input logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] q1;
        logic [W-1:0] q2;
    } sync_t;

    sync_t s;
    sync_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // Per-bit two-stage chain
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            next_s.q1[i] = d_in[i];
            next_s.q2[i] = s.q1[i];
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= {RST_VAL, RST_VAL};
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    assign q_out = s.q2;

endmodule

// [design/param_table_rom.sv]
// Purpose: Parameter table returned by the table read command.
// Assumes: Address is stable for at least one clock before use.
// Notes:   Read data come out of a register.
module param_table_rom #(
    parameter int AW = 8
) (
    input logic ref_clk_in,
    input logic rst_in,
    input logic clk_en_in,
    input logic [AW-1:0] addr_in,
    output logic [7:0] data_out
);

    typedef struct packed {
        logic [7:0] data;
    } rom_t;

    rom_t s;
    rom_t next_s;

    ////////////////////////////////////////////////////////////////////////
    // Table contents: header signature, two header bytes, then erased bytes
    always_comb begin
        next_s = s;
        case (addr_in)
            AW'(0): next_s.data = 8'h53;
            AW'(1): next_s.data = 8'h46;
            AW'(2): next_s.data = 8'h44;
            AW'(3): next_s.data = 8'h50;
            AW'(4): next_s.data = 8'h06;
            AW'(5): next_s.data = 8'h01;
            default: next_s.data = 8'hff;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    assign data_out = s.data;

endmodule

// [design/flash_suspend_resume_reset_ctl.sv]
// Purpose: Command decode for suspend, resume, idle, software and pin reset
//          and parameter table read of a serial flash.
// Assumes: Serial pins are sampled by the 200 MHz core clock.
// Notes:   Data output is single-line on the serial output pin.

// How it works
// - Latch clear, status, config reads pass suspend
// - Security, signature, reset, idle pass suspend immediately
// - Resume restarts the suspended operation
// - Resume sets latch, busy; clears suspend flags
// - Resumed operation runs to done or suspend
// - Resume ignored in continuous read mode
// - Idle only cancels a pending reset arm
// - Opcode is eight or two clocks
// - Fire resets only straight after arm
// - Software reset returns standby and defaults
// - Software reset aborts program or erase
// - Table read: opcode, address, dummy, data
// - Reset pin low long enough resets
// - Pin reset returns standby with defaults
// - Pin reset aborts, output floats throughout
// - Power-up in standby, write latch cleared
// - Resume has two opcodes
// - Suspend flags are security bits two, three
// - Suspend latency then latch clear, flag set
module flash_suspend_resume_reset_ctl #(
    parameter int SUSPEND_LAT_CYC = 40,
    parameter logic [7:0] SIGNATURE = 8'h5c // Arbitrary value
) (
    input logic ref_clk_in,
    input logic rst_in,
    input logic clk_en_in,
    input logic sclk_in,
    input logic cs_n_in,
    input logic [flash_ctl_pkg::IO_W-1:0] io_in,
    input logic hw_reset_n_in,
    input logic quad_mode_in,
    input logic cont_read_mode_in,
    input logic op_start_in,
    input logic op_erase_in,
    input logic suspend_req_in,
    input logic op_done_in,
    output logic so_out,
    output logic so_oe_out,
    output logic wel_out,
    output logic wip_out,
    output logic prog_susp_out,
    output logic erase_susp_out,
    output flash_ctl_pkg::mode_t mode_out,
    output logic op_resume_out,
    output logic op_abort_out
);
    import flash_ctl_pkg::*;

    localparam int LAT_W = $clog2(SUSPEND_LAT_CYC + 1);
    localparam int HW_W = $clog2(RESET_PULSE_CYC + 1);

    typedef struct packed {
        mode_t mode;
        logic erase;
        logic [LAT_W-1:0] lat;
        logic write_enable_latch;
        logic write_in_progress;
        logic program_suspended_flag;
        logic erase_suspended_flag;
        logic armed;
        logic [2:0] bits;
        logic [2:0] nbyte;
        logic [7:0] shreg;
        logic [7:0] opc;
        logic [7:0] tx;
        logic [2:0] txbit;
        logic tx_on;
        logic [7:0] addr;
        logic sclk_q;
        logic cs_q;
        logic [HW_W-1:0] hw_cnt;
        logic hw_hold;
        logic so;
        logic so_oe;
        logic abort;
        logic resume;
    } ctl_t;

    ctl_t s;
    ctl_t next_s;

    logic sclk_s;
    logic cs_s;
    logic [IO_W-1:0] io_s;
    logic pin_s;
    logic [7:0] rom_data;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic byte_end;
    logic exec;
    logic ok;
    logic is_resume;
    logic hw_fire;
    logic sw_fire;
    logic [7:0] opc_cur;
    logic [7:0] rd_val;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    input_sync #(
        .W(IO_W + 3),
        .RST_VAL({1'b0, 1'b1, {IO_W{1'b0}}, 1'b1})
    ) u_sync (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .d_in({sclk_in, cs_n_in, io_in, hw_reset_n_in}),
        .q_out({sclk_s, cs_s, io_s, pin_s})
    );

    param_table_rom #(
        .AW(8)
    ) u_rom (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .addr_in(s.addr),
        .data_out(rom_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Command filter while suspending or suspended
    function automatic logic accepted(mode_t m, logic [7:0] o);
        logic quick;
        quick = o inside {OP_LATCH_CLR, OP_STATUS_RD, OP_CONFIG_RD,
                          OP_SECURITY_RD, OP_SIGNATURE_RD, OP_RESET_ARM,
                          OP_RESET_FIRE, OP_IDLE};
        case (m)
            ST_SUSPENDING: accepted = quick;
            ST_SUSPENDED: accepted = quick || o == OP_RESUME_A ||
                                     o == OP_RESUME_B || o == OP_PARAM_RD;
            default: accepted = 1'b1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        next_s.abort = 1'b0;
        next_s.resume = 1'b0;
        next_s.sclk_q = sclk_s;
        next_s.cs_q = cs_s;
        sclk_rise = sclk_s && !s.sclk_q;
        sclk_fall = !sclk_s && s.sclk_q;
        cs_rise = cs_s && !s.cs_q;
        byte_end = quad_mode_in ? (s.bits == 3'd1) : (s.bits == 3'd7);
        exec = cs_rise && s.nbyte == 3'd1 && s.bits == 3'd0 && !s.hw_hold;
        ok = accepted(s.mode, s.opc);
        is_resume = s.opc == OP_RESUME_A || s.opc == OP_RESUME_B;
        sw_fire = exec && s.opc == OP_RESET_FIRE && s.armed;
        hw_fire = !pin_s && s.hw_cnt == HW_W'(RESET_PULSE_CYC - 1);
        opc_cur = quad_mode_in ? {s.shreg[3:0], io_s} : {s.shreg[6:0], io_s[0]};
        rd_val = 8'h00;
        case (s.nbyte == 3'd0 ? opc_cur : s.opc)
            OP_STATUS_RD: begin
                rd_val[WEL_BIT] = s.write_enable_latch;
                rd_val[WIP_BIT] = s.write_in_progress;
            end
            OP_SECURITY_RD: begin
                rd_val[PSB_BIT] = s.program_suspended_flag;
                rd_val[ESB_BIT] = s.erase_suspended_flag;
            end
            OP_CONFIG_RD: rd_val = CONFIG_RESET;
            OP_SIGNATURE_RD: rd_val = SIGNATURE;
            default: rd_val = 8'h00;
        endcase

        // Serial receive and transmit
        if (cs_s || s.hw_hold) begin
            next_s.bits = 3'd0;
            next_s.nbyte = 3'd0;
            next_s.tx_on = 1'b0;
            next_s.so_oe = 1'b0;
        end else if (sclk_rise) begin
            next_s.shreg = opc_cur;
            next_s.bits = byte_end ? 3'd0 : s.bits + 3'd1;
            if (byte_end) begin
                next_s.nbyte = (s.nbyte == 3'd7) ? s.nbyte : s.nbyte + 3'd1;
                if (s.nbyte == 3'd0) begin
                    next_s.opc = opc_cur;
                end
                if (s.nbyte == 3'(ADDR_BYTES)) begin
                    next_s.addr = opc_cur;
                end
                if (s.opc == OP_PARAM_RD && s.nbyte != 3'd0 &&
                    ok && s.nbyte >= 3'(PARAM_HDR_BYTES - 1)) begin
                    next_s.tx = rom_data;
                    next_s.txbit = 3'd7;
                    next_s.tx_on = 1'b1;
                    next_s.addr = s.addr + 8'h01;
                end else if (accepted(s.mode, s.nbyte == 3'd0 ? opc_cur :
                             s.opc) && (s.nbyte == 3'd0 ? opc_cur : s.opc)
                             inside {OP_STATUS_RD, OP_SECURITY_RD,
                             OP_CONFIG_RD, OP_SIGNATURE_RD}) begin
                    next_s.tx = rd_val;
                    next_s.txbit = 3'd7;
                    next_s.tx_on = 1'b1;
                end
            end
        end else if (sclk_fall && s.tx_on) begin
            next_s.so = s.tx[s.txbit];
            next_s.so_oe = 1'b1;
            next_s.txbit = s.txbit - 3'd1;
        end

        // Reset arming: anything but an arm in between disarms
        if (cs_rise) begin
            next_s.armed = exec && ok && s.opc == OP_RESET_ARM;
        end

        // Program and erase sequencing
        case (s.mode)
            ST_STANDBY: begin
                if (op_start_in) begin
                    next_s.mode = ST_BUSY;
                    next_s.write_in_progress = 1'b1;
                    next_s.erase = op_erase_in;
                end
            end
            ST_BUSY: begin
                if (op_done_in) begin
                    next_s.mode = ST_STANDBY;
                    next_s.write_in_progress = 1'b0;
                    next_s.write_enable_latch = 1'b0;
                end else if (suspend_req_in) begin
                    next_s.mode = ST_SUSPENDING;
                    next_s.lat = LAT_W'(SUSPEND_LAT_CYC);
                end
            end
            ST_SUSPENDING: begin
                if (s.lat == '0) begin
                    next_s.mode = ST_SUSPENDED;
                    next_s.write_enable_latch = 1'b0;
                    next_s.write_in_progress = 1'b0;
                    next_s.program_suspended_flag = !s.erase;
                    next_s.erase_suspended_flag = s.erase;
                end else begin
                    next_s.lat = s.lat - LAT_W'(1);
                end
            end
            ST_SUSPENDED: begin
                if (exec && is_resume && !cont_read_mode_in) begin
                    next_s.mode = ST_BUSY;
                    next_s.write_enable_latch = 1'b1;
                    next_s.write_in_progress = 1'b1;
                    next_s.program_suspended_flag = 1'b0;
                    next_s.erase_suspended_flag = 1'b0;
                    next_s.resume = 1'b1;
                end
            end
            default: next_s.mode = ST_STANDBY;
        endcase

        if (exec && ok && s.opc == OP_LATCH_CLR) begin
            next_s.write_enable_latch = 1'b0;
        end

        // Reset pin low-time counter
        if (!pin_s) begin
            next_s.hw_hold = 1'b1;
            next_s.so_oe = 1'b0;
            if (s.hw_cnt != HW_W'(RESET_PULSE_CYC)) begin
                next_s.hw_cnt = s.hw_cnt + HW_W'(1);
            end
        end else begin
            next_s.hw_hold = 1'b0;
            next_s.hw_cnt = '0;
        end

        // Software or pin reset back to power-on defaults
        if (sw_fire || hw_fire) begin
            next_s.abort = s.mode != ST_STANDBY;
            next_s.mode = ST_STANDBY;
            next_s.write_enable_latch = 1'b0;
            next_s.write_in_progress = 1'b0;
            next_s.program_suspended_flag = 1'b0;
            next_s.erase_suspended_flag = 1'b0;
            next_s.armed = 1'b0;
            next_s.tx_on = 1'b0;
            next_s.so_oe = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s <= '0;
            s.mode <= ST_STANDBY;
            s.cs_q <= 1'b1;
        end else if (clk_en_in) begin
            s <= next_s;
        end
    end

    assign so_out = s.so;
    assign so_oe_out = s.so_oe;
    assign wel_out = s.write_enable_latch;
    assign wip_out = s.write_in_progress;
    assign prog_susp_out = s.program_suspended_flag;
    assign erase_susp_out = s.erase_suspended_flag;
    assign mode_out = s.mode;
    assign op_resume_out = s.resume;
    assign op_abort_out = s.abort;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence resume_go;
        clk_en_in && exec && is_resume && s.mode == ST_SUSPENDED &&
            !cont_read_mode_in && !hw_fire;
    endsequence
    sequence latency_end;
        clk_en_in && s.mode == ST_SUSPENDING && s.lat == '0 && !hw_fire &&
            !sw_fire;
    endsequence
    sequence pin_low_run;
        (clk_en_in && !pin_s)[*2];
    endsequence

    a_resume_sets_bits: assert property (resume_go |=>
        s.write_enable_latch && s.write_in_progress && !s.program_suspended_flag && !s.erase_suspended_flag && s.mode == ST_BUSY && s.resume)
        else $error("resume did not set latch and busy");
    a_resume_cont_read: assert property (clk_en_in && exec && is_resume &&
        cont_read_mode_in && s.mode == ST_SUSPENDED && !hw_fire |=>
        s.mode == ST_SUSPENDED && !s.resume)
        else $error("resume taken in continuous read mode");
    a_arm_cleared: assert property (clk_en_in && cs_rise &&
        !(exec && s.opc == OP_RESET_ARM) |=> !s.armed)
        else $error("arming survived another command");
    a_idle_no_effect: assert property (clk_en_in && exec &&
        s.opc == OP_IDLE && !op_start_in && !op_done_in && !suspend_req_in &&
        s.mode != ST_SUSPENDING && !hw_fire |=> !s.armed &&
        s.write_enable_latch == $past(s.write_enable_latch) && s.mode == $past(s.mode))
        else $error("idle command changed state");
    a_fire_resets: assert property (clk_en_in && sw_fire |=>
        s.mode == ST_STANDBY && !s.write_enable_latch && !s.write_in_progress && !s.program_suspended_flag && !s.erase_suspended_flag)
        else $error("software reset left volatile state");
    a_fire_aborts: assert property (clk_en_in && sw_fire &&
        s.mode != ST_STANDBY |=> s.abort ##1 !s.abort)
        else $error("software reset did not abort operation");
    a_suspend_flags: assert property (latency_end |=>
        s.mode == ST_SUSPENDED && !s.write_enable_latch && (s.program_suspended_flag != s.erase_suspended_flag))
        else $error("suspend did not set flag");
    a_susp_filter: assert property (clk_en_in && exec &&
        s.mode == ST_SUSPENDED && !ok && !hw_fire |=>
        s.mode == ST_SUSPENDED)
        else $error("unlisted command left suspend");
    a_latch_clear: assert property (clk_en_in && exec &&
        s.opc == OP_LATCH_CLR && s.mode == ST_SUSPENDED |=> !s.write_enable_latch)
        else $error("latch clear refused in suspend");
    a_pin_reset_hiz: assert property (pin_low_run |-> ##1 !s.so_oe)
        else $error("output driven during pin reset");
    a_pin_reset_done: assert property (clk_en_in && hw_fire |=>
        s.mode == ST_STANDBY && !s.write_enable_latch && !s.write_in_progress && !s.armed)
        else $error("pin reset left volatile state");
    a_quad_opcode: assert property (clk_en_in && sclk_rise && !cs_s &&
        !s.hw_hold && quad_mode_in && s.bits == 3'd1 && s.nbyte == 3'd0
        |=> s.bits == 3'd0 && s.nbyte == 3'd1)
        else $error("quad opcode not two clocks");

endmodule

// [test/host_spi_model.sv]
// Purpose: Behavioural host that frames commands on the serial link.
// Assumes: Link clock of 80 ns that stands low between frames.
// Notes:   Each read byte is handed over through got_byte and done.
module host_spi_model (
    input wire logic quad_in,
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic [3:0] io_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got_byte;
    event done;

    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        io_out = 4'h5;
    end

    // Send ns bytes of tx, then clock in n bytes from the device
    task automatic frame(input logic [7:0] tx [5], input int ns,
                         input int n);
        cs_n_out = 1'b0;
        #40;
        for (int i = 0; i < ns; i++) begin
            for (int k = 0; k < (quad_in ? 2 : 8); k++) begin
                if (quad_in)
                    io_out = (k == 0) ? tx[i][7:4] : tx[i][3:0];
                else
                    io_out = {3'($urandom), tx[i][7 - k]};
                #40 sclk_out = 1'b1;
                #40 sclk_out = 1'b0;
            end
        end
        io_out = ~io_out;
        for (int b = 0; b < n; b++) begin
            for (int k = 0; k < 8; k++) begin
                #40 got_byte[7 - k] = so_oe_in ? so_in : 1'bx;
                sclk_out = 1'b1;
                #40 sclk_out = 1'b0;
            end
            -> done;
        end
        #40 cs_n_out = 1'b1;
        io_out = ~io_out;
        #200;
    endtask
endmodule

// [test/test_flash_suspend_resume_reset_ctl.sv]
// Purpose: Self-checking bench of suspend, resume and reset control.
// Assumes: Suspend latency shortened to two cycles.
// Notes:   Results are matched in order against a queue of notes.
module test_flash_suspend_resume_reset_ctl;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_ctl_pkg::*;
    localparam logic [5:0] WL = 6'h20, WP = 6'h10, PS = 6'h08;
    localparam logic [5:0] ES = 6'h04, RS = 6'h02, AB = 6'h01;
    localparam logic [7:0] SIG = 8'h3c; // Arbitrary signature
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic hw_n = 1'b1;
    logic quad = 1'b0;
    logic cont = 1'b0;
    logic start = 1'b0;
    logic erase = 1'b0;
    logic susp = 1'b0;
    logic done = 1'b0;
    logic sclk, cs_n, so, so_oe, write_enable_latch, write_in_progress, program_suspended_flag, erase_suspended_flag, res_p, abt_p;
    logic [3:0] io;
    mode_t mode;
    logic [8:0] exp_q [$];
    logic [8:0] got;
    event res;
    int miscompares = 0;
    int cmp_count = 0;
    int n_res = 0;
    int n_abt = 0;
    int b_res = 0;
    int b_abt = 0;

    always #2.5 ref_clk_in = ~ref_clk_in;

    flash_suspend_resume_reset_ctl #(.SUSPEND_LAT_CYC(2),
        .SIGNATURE(SIG)) u_dut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(1'b1),
        .sclk_in(sclk), .cs_n_in(cs_n), .io_in(io), .hw_reset_n_in(hw_n),
        .quad_mode_in(quad), .cont_read_mode_in(cont),
        .op_start_in(start), .op_erase_in(erase), .suspend_req_in(susp),
        .op_done_in(done), .so_out(so), .so_oe_out(so_oe), .wel_out(write_enable_latch),
        .wip_out(write_in_progress), .prog_susp_out(program_suspended_flag), .erase_susp_out(erase_suspended_flag),
        .mode_out(mode), .op_resume_out(res_p), .op_abort_out(abt_p));

    host_spi_model u_host (.quad_in(quad), .so_in(so), .so_oe_in(so_oe),
        .sclk_out(sclk), .cs_n_out(cs_n), .io_out(io));

    ////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_in) begin
        if (res_p === 1'b1) n_res++;
        if (abt_p === 1'b1) n_abt++;
    end

    always @(u_host.done) begin
        got = {1'b0, u_host.got_byte};
        -> res;
    end

    always @(res) begin
        cmp_count++;
        if (exp_q.size() == 0 || got !== exp_q[0]) begin
            miscompares++;
            $display("unexpected at %0t: got %h", $time, got);
        end
        if (exp_q.size() != 0) void'(exp_q.pop_front());
    end

    ////////////////////////////////////////////////////////////////////
    function automatic logic [8:0] st(mode_t m, logic [5:0] f);
        return {1'b0, m, f};
    endfunction

    task automatic snap(input logic [8:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk_in);
        #1;
        got = {so_oe, mode, write_enable_latch, write_in_progress, program_suspended_flag, erase_suspended_flag, n_res != b_res,
               n_abt != b_abt};
        b_res = n_res;
        b_abt = n_abt;
        -> res;
    endtask

    task automatic rd(input logic [7:0] tx [5], input int ns, input int n,
                      input logic [7:0] e);
        repeat (n) exp_q.push_back({1'b0, e});
        u_host.frame(tx, ns, n);
    endtask

    task automatic cmd(input logic [7:0] b);
        u_host.frame('{b, 8'h00, 8'h00, 8'h00, 8'h00}, 1, 0);
    endtask

    task automatic op(input logic s, input logic p, input logic d,
                      input logic e);
        @(posedge ref_clk_in);
        start <= s;
        susp <= p;
        done <= d;
        erase <= e;
        @(posedge ref_clk_in);
        start <= 1'b0;
        susp <= 1'b0;
        done <= 1'b0;
        repeat (8) @(posedge ref_clk_in);
    endtask

    task automatic lvl(input logic q, input logic c);
        @(posedge ref_clk_in);
        quad <= q;
        cont <= c;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        #200_000;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        logic [7:0] x;
        void'($urandom(32'h7ac2));
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        snap(st(ST_STANDBY, 6'h00));
        rd('{OP_STATUS_RD, 0, 0, 0, 0}, 1, 1, 8'h00);
        $display("test power_on done");
        op(1'b1, 1'b0, 1'b0, 1'b0);
        snap(st(ST_BUSY, WP));
        op(1'b0, 1'b1, 1'b0, 1'b0);
        snap(st(ST_SUSPENDED, PS));
        rd('{OP_SECURITY_RD, 0, 0, 0, 0}, 1, 1, 8'h04);
        rd('{OP_STATUS_RD, 0, 0, 0, 0}, 1, 2, 8'h00);
        rd('{OP_CONFIG_RD, 0, 0, 0, 0}, 1, 1, CONFIG_RESET);
        cmd(OP_LATCH_CLR);
        rd('{OP_SIGNATURE_RD, 0, 0, 0, 0}, 1, 1, SIG);
        do x = 8'($urandom);
        while (x inside {8'h04, 8'h05, 8'h15, 8'h2b, 8'hab, 8'h66, 8'h99,
                         8'h00, 8'h7a, 8'h30, 8'h5a});
        cmd(x);
        lvl(1'b0, 1'b1);
        cmd(OP_RESUME_A);
        snap(st(ST_SUSPENDED, PS));
        lvl(1'b0, 1'b0);
        cmd(OP_RESUME_A);
        snap(st(ST_BUSY, WL | WP | RS));
        op(1'b0, 1'b0, 1'b1, 1'b0);
        snap(st(ST_STANDBY, 6'h00));
        $display("test program_suspend done");
        op(1'b1, 1'b0, 1'b0, 1'b1);
        op(1'b0, 1'b1, 1'b0, 1'b1);
        snap(st(ST_SUSPENDED, ES));
        rd('{OP_SECURITY_RD, 0, 0, 0, 0}, 1, 1, 8'h08);
        rd('{OP_PARAM_RD, 0, 0, 8'h40, 0}, 5, 2, 8'hff);
        lvl(1'b1, 1'b0);
        cmd(OP_IDLE);
        cmd(OP_RESUME_B);
        snap(st(ST_BUSY, WL | WP | RS));
        op(1'b0, 1'b1, 1'b0, 1'b1);
        snap(st(ST_SUSPENDED, ES));
        cmd(OP_RESUME_A);
        snap(st(ST_BUSY, WL | WP | RS));
        $display("test erase_suspend done");
        cmd(OP_RESET_ARM);
        cmd(OP_IDLE);
        cmd(OP_RESET_FIRE);
        snap(st(ST_BUSY, WL | WP));
        lvl(1'b0, 1'b0);
        cmd(OP_RESET_ARM);
        rd('{OP_STATUS_RD, 0, 0, 0, 0}, 1, 1, 8'h03);
        cmd(OP_RESET_FIRE);
        snap(st(ST_BUSY, WL | WP));
        cmd(OP_LATCH_CLR);
        snap(st(ST_BUSY, WP));
        cmd(OP_RESET_ARM);
        cmd(OP_RESET_FIRE);
        snap(st(ST_STANDBY, AB));
        $display("test soft_reset done");
        // No serial command follows a reset until the end of the run
        op(1'b1, 1'b0, 1'b0, 1'b0);
        hw_n <= 1'b0;
        repeat (100) @(posedge ref_clk_in);
        hw_n <= 1'b1;
        repeat (10) @(posedge ref_clk_in);
        snap(st(ST_BUSY, WP));
        hw_n <= 1'b0;
        repeat (1000) @(posedge ref_clk_in);
        snap(st(ST_BUSY, WP));
        repeat (1100) @(posedge ref_clk_in);
        snap(st(ST_STANDBY, AB));
        hw_n <= 1'b1;
        repeat (2000) @(posedge ref_clk_in);
        $display("test pin_reset done");
        summarize();
    end
endmodule
